// ===== rtl/mt_ctx_pkg.sv
package mt_ctx_pkg;

    // sizes
    localparam int CTX_NUM = 8;
    localparam int CTX_W   = 3;
    localparam int VP_W    = 2;
    localparam int QUAL_W  = 31;
    localparam int ADDR_W  = 8;
    localparam int IDX_W   = 10;

    // register offsets
    localparam logic [ADDR_W-1:0] OFF_VPCTL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_QMASK   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CONFIG  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ACTIVE  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_DYNALOC = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_SCHEDEN = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_BINDING = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_HALT    = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h20;

    // field positions
    localparam int VPCTL_TARGET_LSB = 0;
    localparam int VPCTL_YSI_BIT    = 15;
    localparam int VPCTL_EXC_LSB    = 16;
    localparam int CFG_MVP_BIT      = 0;
    localparam int CFG_MT_BIT       = 1;
    localparam int CFG_AT_LSB       = 2;
    localparam int CFG_FR_BIT       = 4;
    localparam int CFG_HIGH_LSB     = 8;
    localparam int STAT_BLOCKED_BIT = 0;
    localparam int STAT_CTX_LSB     = 8;

    // reset values
    localparam logic [31:0] RST_VPCTL   = 32'h0000_0000;
    localparam logic [31:0] RST_QMASK   = 32'h0000_0000;
    localparam logic [31:0] RST_CONFIG  = 32'h0000_0703;
    localparam logic [31:0] RST_ACTIVE  = 32'h0000_0001;
    localparam logic [31:0] RST_DYNALOC = 32'h0000_00FF;
    localparam logic [31:0] RST_SCHEDEN = 32'h0000_0000;
    localparam logic [31:0] RST_BINDING = 32'h0000_0000;
    localparam logic [31:0] RST_HALT    = 32'h0000_0000;

    // thread exception codes
    localparam logic [2:0] EXC_UNDERFLOW    = 3'h0;
    localparam logic [2:0] EXC_INVALID_QUAL = 3'h2;
    localparam logic [2:0] EXC_SCHED        = 3'h4;

    // special descriptors
    localparam logic [31:0] DESC_DEALLOC = 32'h0000_0000;
    localparam logic [31:0] DESC_RESCHED = 32'hFFFF_FFFF;
    localparam logic [31:0] DESC_POLL    = 32'hFFFF_FFFE;

    // halt register of the target context in the privileged space
    localparam logic [4:0] HALT_REG_NUM = 5'h02;
    localparam logic [2:0] HALT_REG_SEL = 3'h4;

    typedef enum logic {OP_MOVE, OP_YIELD} op_type;

    typedef enum logic [3:0] {
        DST_CPR, DST_GPR, DST_ACC_LO, DST_ACC_HI, DST_ACC_X, DST_ACC_CTRL,
        DST_FPR, DST_FP_CONTROL_REGS, DST_COP2_DATA, DST_COP2_CTRL
    } dest_type;

    typedef enum logic [1:0] {EXK_NONE, EXK_COP_UNUSABLE, EXK_RESERVED, EXK_THREAD} exc_kind_type;

    typedef enum logic {ST_IDLE = 1'b0, ST_BLOCKED = 1'b1} fsm_type;

    typedef struct packed {
        logic             valid;
        op_type           op;
        logic [CTX_W-1:0] issuer;
        logic             cop_usable;
        logic [31:0]      value;
        logic [4:0]       rd;
        logic [4:0]       rx;
        logic             u;
        logic [2:0]       sel;
        logic             h;
    } cmd_type;

    typedef struct packed {
        logic             valid;
        dest_type         dest;
        logic [CTX_W-1:0] ctx;
        logic [IDX_W-1:0] index;
        logic [2:0]       sel;
        logic             half;
        logic [31:0]      data;
    } wr_type;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [4:0]  rd;
        logic [31:0] value;
    } result_type;

    typedef struct packed {
        logic         valid;
        exc_kind_type kind;
        logic [2:0]   code;
    } exc_type;

endpackage

// ===== rtl/mt_dest_decode.sv
`timescale 1ns/1ps
`default_nettype none
module mt_dest_decode
    import mt_ctx_pkg::*;
(
    // instruction fields
    input  wire logic             u,
    input  wire logic [2:0]       sel,
    input  wire logic [4:0]       rd,
    input  wire logic [4:0]       rx,
    input  wire logic             h,
    // floating-point width mode
    input  wire logic [1:0]       arch_type_field,
    input  wire logic             fp_reg_mode_bit,
    // decoded destination
    output dest_type              dest,
    output logic [IDX_W-1:0]      index,
    output logic                  half,
    output logic                  undef
);
    logic fp_match;
    logic fp_split;

    // register widths match, or 32-bit general beside 64-bit floating
    assign fp_match = (arch_type_field == 2'h0 && !fp_reg_mode_bit) ||
                      arch_type_field == 2'h1 || arch_type_field == 2'h2;
    assign fp_split = arch_type_field == 2'h0 && fp_reg_mode_bit;

    // destination decode by unit, select and destination field
    always_comb begin
        dest  = DST_CPR;
        index = {5'h00, rd};
        half  = h;
        undef = 1'b0;
        if (!u) begin
            dest = DST_CPR;
        end else begin
            unique case (sel)
                3'h0: dest = DST_GPR;
                3'h1: begin
                    // accumulator number sits in rd[3:2], part in rd[1:0]
                    index = {8'h00, rd[3:2]};
                    if (rd == 5'h10) begin
                        dest = DST_ACC_CTRL;
                    end else if (rd[4] || rd[1:0] == 2'h3) begin
                        undef = 1'b1;
                    end else begin
                        unique case (rd[1:0])
                            2'h0: dest = DST_ACC_LO;
                            2'h1: dest = DST_ACC_HI;
                            default: dest = DST_ACC_X;
                        endcase
                    end
                end
                3'h2: begin
                    dest = DST_FPR;
                    if (fp_match) begin
                        half  = 1'b0;
                        undef = h;
                    end else if (!fp_split) begin
                        undef = 1'b1;
                    end
                end
                3'h3: dest = DST_FP_CONTROL_REGS;
                3'h4: begin
                    dest  = DST_COP2_DATA;
                    index = {rx, rd};
                end
                3'h5: begin
                    dest  = DST_COP2_CTRL;
                    index = {rx, rd};
                end
                default: undef = 1'b1;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== rtl/mt_ctx_scan.sv
`timescale 1ns/1ps
`default_nettype none
module mt_ctx_scan
    import mt_ctx_pkg::*;
#(
    parameter int NCTX = CTX_NUM
)(
    // per-context state
    input  wire logic [NCTX-1:0]           activated,
    input  wire logic [NCTX-1:0]           dyn_alloc_allowed,
    input  wire logic [NCTX-1:0]           halted,
    input  wire logic [NCTX-1:0][VP_W-1:0] binding,
    // the issuing context and the highest implemented context index
    input  wire logic [CTX_W-1:0]          issuer,
    input  wire logic [CTX_W-1:0]          highest_ctx_index,
    // another context could take over
    output logic                           other_ok
);
    logic [NCTX-1:0] cand;

    // one candidate test per context, limited to implemented contexts
    for (genvar t = 0; t < NCTX; t++) begin : g_ctx
        assign cand[t] = t <= int'(highest_ctx_index) && t != int'(issuer) &&
                         binding[t] == binding[issuer] && dyn_alloc_allowed[t] &&
                         !halted[t] && activated[t];
    end

    assign other_ok = |cand;
endmodule
`default_nettype wire

// ===== rtl/mt_ctx_unit.sv
// Function
// - halt bit written by move persists until rewritten
// - move is no-op on foreign binding without privilege, or out of range
// - half-select picks bits 63..32, no sign extension
// - unit 0 privileged register, unit 1 select 0 general
// - select 1 decodes accumulator parts and control
// - select 2 writes floating register, full or half
// - selects 3, 4, 5 floating control, coprocessor two
// - move raises only unusable or reserved exceptions
// - target context comes from control register index
// - zero descriptor deallocates issuer, clears activated
// - minus one descriptor invokes the scheduler
// - minus two descriptor only returns qualifier vector
// - positive descriptor is masked qualifier bit vector
// - positive descriptor blocks until enabled qualifier matches
// - completion writes masked qualifiers unless destination zero
// - unmasked qualifier bit raises thread exception code 2
// - zero descriptor with no other runnable context raises underflow code 0
// - intercept bits both set raise code 4
// - yield without multithreading raises reserved instruction
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module mt_ctx_unit
    import mt_ctx_pkg::*;
#(
    parameter int NCTX = CTX_NUM
)(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    // instruction issue
    input  wire cmd_type           cmd,
    output logic                   cmd_ready,
    // qualifier inputs
    input  wire logic [QUAL_W-1:0] yield_qualifier_bits,
    // effects
    output wr_type                 ctx_wr,
    output result_type             result,
    output exc_type                exc,
    output logic                   sched_req
);
    typedef struct packed {
        fsm_type                   fsm;
        logic [CTX_W-1:0]          target_ctx_index;
        logic                      yield_sched_intercept;
        logic [2:0]                thread_exc_code;
        logic [QUAL_W-1:0]         qualifier_enable_mask;
        logic                      multi_vp_privilege;
        logic                      mt_supported;
        logic [1:0]                arch_type_field;
        logic                      fp_reg_mode_bit;
        logic [CTX_W-1:0]          highest_ctx_index;
        logic [NCTX-1:0]           activated;
        logic [NCTX-1:0]           dyn_alloc_allowed;
        logic [NCTX-1:0]           ctx_sched_intercept_enable;
        logic [NCTX-1:0][VP_W-1:0] ctx_vp_binding;
        logic [NCTX-1:0]           ctx_halt_bit;
        logic [QUAL_W-1:0]         wait_desc;
        logic [4:0]                wait_rd;
        logic [CTX_W-1:0]          wait_ctx;
        logic [31:0]               rdata;
        wr_type                    wr;
        result_type                res;
        exc_type                   ex;
        logic                      sched;
    } state_type;

    state_type s_q;
    state_type s_d;

    dest_type         dec_dest;
    logic [IDX_W-1:0] dec_index;
    logic             dec_half;
    logic             dec_undef;
    logic             other_ok;
    logic [31:0]      desc;
    logic [QUAL_W-1:0] enabled_q;
    logic [31:0]      poll_value;

    mt_dest_decode u_dec (
        .u               (cmd.u),
        .sel             (cmd.sel),
        .rd              (cmd.rd),
        .rx              (cmd.rx),
        .h               (cmd.h),
        .arch_type_field (s_q.arch_type_field),
        .fp_reg_mode_bit (s_q.fp_reg_mode_bit),
        .dest            (dec_dest),
        .index           (dec_index),
        .half            (dec_half),
        .undef           (dec_undef)
    );

    mt_ctx_scan #(.NCTX(NCTX)) u_scan (
        .activated         (s_q.activated),
        .dyn_alloc_allowed (s_q.dyn_alloc_allowed),
        .halted            (s_q.ctx_halt_bit),
        .binding           (s_q.ctx_vp_binding),
        .issuer            (cmd.issuer),
        .highest_ctx_index (s_q.highest_ctx_index),
        .other_ok          (other_ok)
    );

    // qualifier inputs as seen through the mask; unmasked bits read zero
    assign desc       = cmd.value;
    assign enabled_q  = yield_qualifier_bits & s_q.qualifier_enable_mask;
    assign poll_value = {1'b0, enabled_q};

    // register writes, instruction execution and read data
    always_comb begin
        s_d       = s_q;
        s_d.wr    = '0;
        s_d.res   = '0;
        s_d.ex    = '0;
        s_d.sched = 1'b0;
        s_d.rdata = 32'h0000_0000;

        // software writes; an instruction in the same cycle wins below
        if (reg_wr) begin
            unique case (reg_addr)
                OFF_VPCTL: begin
                    s_d.target_ctx_index      = reg_wdata[VPCTL_TARGET_LSB +: CTX_W];
                    s_d.yield_sched_intercept = reg_wdata[VPCTL_YSI_BIT];
                end
                OFF_QMASK: s_d.qualifier_enable_mask = reg_wdata[QUAL_W-1:0];
                OFF_CONFIG: begin
                    s_d.multi_vp_privilege = reg_wdata[CFG_MVP_BIT];
                    s_d.mt_supported       = reg_wdata[CFG_MT_BIT];
                    s_d.arch_type_field    = reg_wdata[CFG_AT_LSB +: 2];
                    s_d.fp_reg_mode_bit    = reg_wdata[CFG_FR_BIT];
                    s_d.highest_ctx_index  = reg_wdata[CFG_HIGH_LSB +: CTX_W];
                end
                OFF_ACTIVE:  s_d.activated = reg_wdata[NCTX-1:0];
                OFF_DYNALOC: s_d.dyn_alloc_allowed = reg_wdata[NCTX-1:0];
                OFF_SCHEDEN: s_d.ctx_sched_intercept_enable = reg_wdata[NCTX-1:0];
                OFF_BINDING: s_d.ctx_vp_binding = reg_wdata[NCTX*VP_W-1:0];
                OFF_HALT:    s_d.ctx_halt_bit = reg_wdata[NCTX-1:0];
                default: ;
            endcase
        end

        unique case (s_q.fsm)
            ST_IDLE: begin
                if (cmd.valid && cmd.op == OP_MOVE) begin
                    if (!s_q.mt_supported) begin
                        s_d.ex = '{1'b1, EXK_RESERVED, 3'h0};
                    end else if (!cmd.cop_usable) begin
                        s_d.ex = '{1'b1, EXK_COP_UNUSABLE, 3'h0};
                    end else if ((!s_q.multi_vp_privilege &&
                                  s_q.ctx_vp_binding[s_q.target_ctx_index] != s_q.ctx_vp_binding[cmd.issuer]) ||
                                 s_q.target_ctx_index > s_q.highest_ctx_index) begin
                        s_d.wr.valid = 1'b0;
                    end else if (!dec_undef) begin
                        // reserved encodings write nothing
                        s_d.wr.valid = 1'b1;
                        s_d.wr.dest  = dec_dest;
                        s_d.wr.ctx   = s_q.target_ctx_index;
                        s_d.wr.index = dec_index;
                        s_d.wr.sel   = cmd.sel;
                        s_d.wr.half  = dec_half;
                        s_d.wr.data  = cmd.value;
                        // the halt bit is held here so it cannot fade
                        if (!cmd.u && cmd.rd == HALT_REG_NUM && cmd.sel == HALT_REG_SEL) begin
                            s_d.ctx_halt_bit[s_q.target_ctx_index] = cmd.value[0];
                        end
                    end
                end else if (cmd.valid && cmd.op == OP_YIELD) begin
                    s_d.res = '{1'b0, cmd.rd != 5'h00, cmd.rd, poll_value};
                    if (!s_q.mt_supported) begin
                        s_d.ex = '{1'b1, EXK_RESERVED, 3'h0};
                    end else if (desc == DESC_POLL || $signed(desc) < $signed(DESC_POLL)) begin
                        s_d.res.valid = 1'b1;
                    end else if (desc == DESC_DEALLOC && !other_ok) begin
                        s_d.ex = '{1'b1, EXK_THREAD, EXC_UNDERFLOW};
                        s_d.thread_exc_code = EXC_UNDERFLOW;
                    end else if (!desc[31] && desc != DESC_DEALLOC &&
                                 (desc[QUAL_W-1:0] & ~s_q.qualifier_enable_mask) != '0) begin
                        s_d.ex = '{1'b1, EXK_THREAD, EXC_INVALID_QUAL};
                        s_d.thread_exc_code = EXC_INVALID_QUAL;
                    end else if (s_q.yield_sched_intercept &&
                                 s_q.ctx_sched_intercept_enable[cmd.issuer]) begin
                        s_d.ex = '{1'b1, EXK_THREAD, EXC_SCHED};
                        s_d.thread_exc_code = EXC_SCHED;
                    end else if (desc == DESC_DEALLOC) begin
                        s_d.activated[cmd.issuer] = 1'b0;
                        s_d.sched     = 1'b1;
                        s_d.res.valid = 1'b1;
                    end else if (desc == DESC_RESCHED) begin
                        s_d.sched     = 1'b1;
                        s_d.res.valid = 1'b1;
                    end else if ((desc[QUAL_W-1:0] & enabled_q) != '0) begin
                        s_d.res.valid = 1'b1;
                        s_d.sched     = 1'b1;
                    end else begin
                        // park the thread until a matching qualifier fires
                        s_d.fsm       = ST_BLOCKED;
                        s_d.wait_desc = desc[QUAL_W-1:0];
                        s_d.wait_rd   = cmd.rd;
                        s_d.wait_ctx  = cmd.issuer;
                        s_d.sched     = 1'b1;
                    end
                end
            end
            ST_BLOCKED: begin
                // the unit is held, so a move behind it stalls as well
                if ((s_q.wait_desc & enabled_q) != '0) begin
                    s_d.fsm = ST_IDLE;
                    s_d.res = '{1'b1, s_q.wait_rd != 5'h00, s_q.wait_rd, poll_value};
                    s_d.sched = 1'b1;
                end
            end
        endcase

        // read data in the cycle after the strobe
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_VPCTL: begin
                    s_d.rdata[VPCTL_TARGET_LSB +: CTX_W] = s_q.target_ctx_index;
                    s_d.rdata[VPCTL_YSI_BIT]             = s_q.yield_sched_intercept;
                    s_d.rdata[VPCTL_EXC_LSB +: 3]        = s_q.thread_exc_code;
                end
                OFF_QMASK: s_d.rdata[QUAL_W-1:0] = s_q.qualifier_enable_mask;
                OFF_CONFIG: begin
                    s_d.rdata[CFG_MVP_BIT]             = s_q.multi_vp_privilege;
                    s_d.rdata[CFG_MT_BIT]              = s_q.mt_supported;
                    s_d.rdata[CFG_AT_LSB +: 2]         = s_q.arch_type_field;
                    s_d.rdata[CFG_FR_BIT]              = s_q.fp_reg_mode_bit;
                    s_d.rdata[CFG_HIGH_LSB +: CTX_W]   = s_q.highest_ctx_index;
                end
                OFF_ACTIVE:  s_d.rdata[NCTX-1:0] = s_q.activated;
                OFF_DYNALOC: s_d.rdata[NCTX-1:0] = s_q.dyn_alloc_allowed;
                OFF_SCHEDEN: s_d.rdata[NCTX-1:0] = s_q.ctx_sched_intercept_enable;
                OFF_BINDING: s_d.rdata[NCTX*VP_W-1:0] = s_q.ctx_vp_binding;
                OFF_HALT:    s_d.rdata[NCTX-1:0] = s_q.ctx_halt_bit;
                OFF_STATUS: begin
                    s_d.rdata[STAT_BLOCKED_BIT]         = s_q.fsm == ST_BLOCKED;
                    s_d.rdata[STAT_CTX_LSB +: CTX_W]    = s_q.wait_ctx;
                end
                default: ;
            endcase
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q                            <= '0;
            s_q.fsm                        <= ST_IDLE;
            s_q.target_ctx_index           <= RST_VPCTL[VPCTL_TARGET_LSB +: CTX_W];
            s_q.yield_sched_intercept      <= RST_VPCTL[VPCTL_YSI_BIT];
            s_q.thread_exc_code            <= RST_VPCTL[VPCTL_EXC_LSB +: 3];
            s_q.qualifier_enable_mask      <= RST_QMASK[QUAL_W-1:0];
            s_q.multi_vp_privilege         <= RST_CONFIG[CFG_MVP_BIT];
            s_q.mt_supported               <= RST_CONFIG[CFG_MT_BIT];
            s_q.arch_type_field            <= RST_CONFIG[CFG_AT_LSB +: 2];
            s_q.fp_reg_mode_bit            <= RST_CONFIG[CFG_FR_BIT];
            s_q.highest_ctx_index          <= RST_CONFIG[CFG_HIGH_LSB +: CTX_W];
            s_q.activated                  <= RST_ACTIVE[NCTX-1:0];
            s_q.dyn_alloc_allowed          <= RST_DYNALOC[NCTX-1:0];
            s_q.ctx_sched_intercept_enable <= RST_SCHEDEN[NCTX-1:0];
            s_q.ctx_vp_binding             <= RST_BINDING[NCTX*VP_W-1:0];
            s_q.ctx_halt_bit               <= RST_HALT[NCTX-1:0];
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state flops
    assign reg_rdata = s_q.rdata;
    assign cmd_ready = s_q.fsm == ST_IDLE;
    assign ctx_wr    = s_q.wr;
    assign result    = s_q.res;
    assign exc       = s_q.ex;
    assign sched_req = s_q.sched;
endmodule
`default_nettype wire

// ===== tb/mt_ctx_unit_properties.sv
`timescale 1ns/1ps
`default_nettype none
module mt_ctx_unit_properties
    import mt_ctx_pkg::*;
#(
    parameter int NCTX = CTX_NUM
)(
    // clock, reset, register port
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    // instruction side
    input wire cmd_type           cmd,
    input wire logic              cmd_ready,
    input wire logic [QUAL_W-1:0] yield_qualifier_bits,
    input wire wr_type            ctx_wr,
    input wire result_type        result,
    input wire exc_type           exc,
    input wire logic              sched_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // accepted commands; a refused one must not count as a cause
    wire mv = cmd.valid && cmd_ready && cmd.op == OP_MOVE;
    wire yl = cmd.valid && cmd_ready && cmd.op == OP_YIELD;
    chk_move_no_thread: assert property ($past(mv) && exc.valid |-> exc.kind != EXK_THREAD)
        else $error("move raised a thread exception");
    chk_move_data_raw: assert property (ctx_wr.valid |-> ctx_wr.data == $past(cmd.value))
        else $error("move data altered");
    chk_unit0_priv: assert property ($past(mv && !cmd.u) && ctx_wr.valid |-> ctx_wr.dest == DST_CPR)
        else $error("unit 0 not privileged");
    chk_gpr_index: assert property ($past(mv && cmd.u && cmd.sel == 3'h0) && ctx_wr.valid |->
        ctx_wr.dest == DST_GPR && ctx_wr.index == IDX_W'($past(cmd.rd))) else $error("general register decode");
    chk_poll_no_sched: assert property ($past(yl && cmd.value == DESC_POLL) |-> !sched_req)
        else $error("poll invoked scheduler");
    chk_resched_runs: assert property ($past(yl && cmd.value == DESC_RESCHED) |-> sched_req || exc.valid)
        else $error("reschedule without scheduler");
    chk_blocked_quiet: assert property (!cmd_ready |-> !result.valid && !ctx_wr.valid && !exc.valid)
        else $error("activity while blocked");
    chk_result_masked: assert property (result.valid |-> result.write == (result.rd != 5'h0) &&
        (result.value[30:0] & ~$past(yield_qualifier_bits)) == 31'h0) else $error("result not qualifier");
endmodule
bind mt_ctx_unit mt_ctx_unit_properties #(.NCTX(NCTX)) u_mt_ctx_unit_properties (.mclk(mclk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cmd(cmd), .cmd_ready(cmd_ready), .yield_qualifier_bits(yield_qualifier_bits), .ctx_wr(ctx_wr),
    .result(result), .exc(exc), .sched_req(sched_req));
`default_nettype wire

// ===== tb/mt_ctx_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; $display("CHECK FAILED %0t got %0h want %0h", $time, a, b); end end
module mt_ctx_unit_tb;
    import mt_ctx_pkg::*;
    logic              mclk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, cmd_ready, sched_req;
    logic [7:0]        reg_addr = 8'h00;
    logic [31:0]       reg_wdata = 32'h0, reg_rdata;
    logic [QUAL_W-1:0] qual = 31'h0;
    cmd_type           cmd = '0;
    wr_type            ctx_wr;
    result_type        result;
    exc_type           exc;
    int                miscompares = 0, checked = 0;
    // 200 MHz
    always #2.5 mclk = ~mclk;
    mt_ctx_unit u_mt_ctx_unit (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd(cmd), .cmd_ready(cmd_ready),
        .yield_qualifier_bits(qual), .ctx_wr(ctx_wr), .result(result), .exc(exc), .sched_req(sched_req));
    // bus and issue helpers, all drive right after an edge
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // outputs are looked at 1 ns after the taking edge
    task automatic go(input op_type op, input logic [31:0] v, input logic [4:0] rd, input logic u, input logic [2:0] s);
        @(posedge mclk);
        cmd <= '{1'h1, op, 3'h0, 1'h1, v, rd, 5'h00, u, s, 1'h0};
        @(posedge mclk);
        cmd.valid <= 1'h0;
        #1;
    endtask
    task automatic t_move;
        r(OFF_STATUS, 32'h0);
        w(OFF_VPCTL, 32'h0000_0002);
        go(OP_MOVE, 32'h0000_0001, HALT_REG_NUM, 1'h0, HALT_REG_SEL);
        go(OP_MOVE, 32'h8000_0001, 5'h05, 1'h1, 3'h0);
        `CHK(ctx_wr, {1'h1, DST_GPR, 3'h2, 10'h005, 3'h0, 1'h0, 32'h8000_0001})
        go(OP_MOVE, 32'h0000_0009, 5'h10, 1'h1, 3'h1);
        `CHK(ctx_wr.dest, DST_ACC_CTRL)
        r(OFF_HALT, 32'h0000_0004);
        r(8'h40, 32'h0);
        // target 2 beyond highest 1, then foreign binding without privilege
        w(OFF_CONFIG, 32'h0000_0103);
        go(OP_MOVE, 32'h0000_0003, 5'h05, 1'h1, 3'h0);
        `CHK(ctx_wr.valid, 1'h0)
        w(OFF_CONFIG, 32'h0000_0702);
        w(OFF_BINDING, 32'h0000_0010);
        go(OP_MOVE, 32'h0000_0003, 5'h05, 1'h1, 3'h0);
        `CHK(ctx_wr.valid, 1'h0)
        w(OFF_CONFIG, 32'h0000_0703);
        w(OFF_BINDING, 32'h0);
        $display("move test done");
    endtask
    task automatic t_dealloc;
        go(OP_YIELD, DESC_DEALLOC, 5'h00, 1'h0, 3'h0);
        `CHK(exc, {1'h1, EXK_THREAD, EXC_UNDERFLOW})
        w(OFF_ACTIVE, 32'h0000_0003);
        go(OP_YIELD, DESC_DEALLOC, 5'h00, 1'h0, 3'h0);
        `CHK(sched_req, 1'h1)
        r(OFF_ACTIVE, 32'h0000_0002);
        $display("dealloc test done");
    endtask
    task automatic t_qual;
        w(OFF_QMASK, 32'h0000_0001);
        @(posedge mclk) qual <= 31'h1;
        go(OP_YIELD, DESC_POLL, 5'h04, 1'h0, 3'h0);
        `CHK(result, {1'h1, 1'h1, 5'h04, 32'h0000_0001})
        go(OP_YIELD, 32'h0000_0002, 5'h00, 1'h0, 3'h0);
        `CHK(exc, {1'h1, EXK_THREAD, EXC_INVALID_QUAL})
        r(OFF_VPCTL, 32'h0002_0002);
        @(posedge mclk) qual <= 31'h0;
        go(OP_YIELD, 32'h0000_0001, 5'h03, 1'h0, 3'h0);
        #15;
        `CHK(cmd_ready, 1'h0)
        r(OFF_STATUS, 32'h0000_0001);
        @(posedge mclk) qual <= 31'h1;
        @(posedge mclk);
        #1;
        `CHK(result, {1'h1, 1'h1, 5'h03, 32'h0000_0001})
        $display("qualifier test done");
    endtask
    task automatic t_intercept;
        go(OP_YIELD, DESC_RESCHED, 5'h00, 1'h0, 3'h0);
        `CHK(sched_req, 1'h1)
        w(OFF_VPCTL, 32'h0000_8002);
        w(OFF_SCHEDEN, 32'h0000_0001);
        go(OP_YIELD, DESC_RESCHED, 5'h00, 1'h0, 3'h0);
        `CHK(exc, {1'h1, EXK_THREAD, EXC_SCHED})
        w(OFF_CONFIG, 32'h0000_0701);
        go(OP_YIELD, DESC_RESCHED, 5'h00, 1'h0, 3'h0);
        `CHK(exc.kind, EXK_RESERVED)
        go(OP_MOVE, 32'h0000_0001, 5'h05, 1'h1, 3'h0);
        `CHK(exc.kind, EXK_RESERVED)
        $display("intercept test done");
    endtask
    task automatic end_sim;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'h0;
        t_move;
        t_dealloc;
        t_qual;
        t_intercept;
        end_sim;
    end
    // watchdog: the whole run needs under a hundred cycles
    initial begin
        #20000;
        miscompares++;
        end_sim;
    end
endmodule
`default_nettype wire
